// ===== verilog/bcc_params.svh
/*
 Constants of the cell balance controller: register offsets, field
 positions, reset values and timing counts.
 Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
// Register byte offsets
`define BCC_OFS_CTRL    8'h00
`define BCC_OFS_SEL     8'h04
`define BCC_OFS_CHEN    8'h08
`define BCC_OFS_STAT    8'h0C
`define BCC_OFS_DIS     8'h10
`define BCC_OFS_CNT     8'h14
`define BCC_OFS_THR0    8'h20
`define BCC_THR_WORDS   4
// Control field positions
`define BCC_CTRL_MODE   0
`define BCC_CTRL_GO     2
`define BCC_CTRL_HALT   3
`define BCC_CTRL_RES    4
`define BCC_CTRL_SLPC   5
// Status field positions
`define BCC_STAT_ACT    0
`define BCC_STAT_DONE   1
`define BCC_STAT_WDE    2
`define BCC_STAT_SILENT 3
`define BCC_STAT_SLEEP  4
// Sizes and codes
`define BCC_NCELL       14
`define BCC_THR_W       7
`define BCC_CNT_W       8
`define BCC_SEL_PICK    2'h2
// Reset values
`define BCC_CTRL_RST    6'h00
`define BCC_SEL_RST     28'h0000000
`define BCC_CHEN_RST    14'h0000
// Timing
`define BCC_CLK_HZ      100000000
`define BCC_FINE_STEP_S   4
`define BCC_COARSE_STEP_S 512
`define BCC_FINE_STEP_CYC (`BCC_FINE_STEP_S * `BCC_CLK_HZ)
`define BCC_COARSE_RATIO  (`BCC_COARSE_STEP_S / `BCC_FINE_STEP_S)
`define BCC_WD_TIMEOUT_STEPS 8'hFF
`endif

// ===== verilog/bcc_pkg.sv
/*
 Types of the cell balance controller.
 Assumes bcc_params.svh is included by the design files.
*/
package bcc_pkg;
   // Balancing state, Gray along idle, ongoing, over
   typedef enum logic [1:0] {
      BCC_IDLE    = 2'h0,
      BCC_ONGOING = 2'h1,
      BCC_OVER    = 2'h3
   } bcc_state_t;
   // Power state, Gray along normal, sleep, silent
   typedef enum logic [1:0] {
      BCC_NORMAL = 2'h0,
      BCC_SLEEP  = 2'h1,
      BCC_SILENT = 2'h3
   } bcc_pwr_t;
   // Balancing mode field codes
   typedef enum logic [1:0] {
      BCC_MODE_NONE   = 2'h0,
      BCC_MODE_MANUAL = 2'h1,
      BCC_MODE_TIMED  = 2'h2,
      BCC_MODE_RSVD   = 2'h3
   } bcc_mode_t;
endpackage

// ===== verilog/bcc_step_tick.sv
/*
 Step timebase: a pulse every fine step, or every coarse step.
 Assumes clear and run come from logic on clk_sys.
*/
`timescale 1ns/1ns
`include "bcc_params.svh"
module bcc_step_tick import bcc_pkg::*; #(
   parameter int unsigned TICK_CYC = `BCC_FINE_STEP_CYC,
   parameter int unsigned RATIO    = `BCC_COARSE_RATIO
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Control
   input  wire logic clear,
   input  wire logic run,
   input  wire logic coarse_sel,
   // Step pulse
   output logic      step_tick
);
   logic [31:0] cyc_r;   // Cycles within a fine step
   logic [31:0] div_r;   // Fine steps within a coarse step
   wire  fine_end   = run && (cyc_r == TICK_CYC - 1);
   wire  coarse_end = fine_end && (div_r == RATIO - 1);

   // Coarse step is a whole number of fine steps
   assign step_tick = coarse_sel ? coarse_end : fine_end;

   // Prescaler holds while paused, so a conversion costs no time
   always_ff @(posedge clk_sys) begin
      if (rst || clear) begin
         cyc_r <= 32'h0;
         div_r <= 32'h0;
      end else if (fine_end) begin
         cyc_r <= 32'h0;
         div_r <= coarse_end ? 32'h0 : div_r + 32'h1;
      end else if (run) begin
         cyc_r <= cyc_r + 32'h1;
      end
   end
endmodule

// ===== verilog/bcc_core.sv
/*
 Cell balance controller: mode select, start/stop decode, balancing
 state, per-cell timed thresholds, watchdog, sleep and silent balancing,
 AHB-Lite register slave.
 Assumes single-word AHB-Lite transfers and same-clock power events.
*/
`timescale 1ns/1ns
`include "bcc_params.svh"
module bcc_core import bcc_pkg::*; #(
   parameter int unsigned       TICK_CYC = `BCC_FINE_STEP_CYC,
   parameter logic [`BCC_CNT_W-1:0] WD_STEPS = `BCC_WD_TIMEOUT_STEPS
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Power and measurement events
   input  wire logic        enter_sleep_command,
   input  wire logic        comm_timeout,
   input  wire logic        wake_request,
   input  wire logic        conv_busy,
   // Balancing outputs
   output logic [`BCC_NCELL-1:0] discharge_en,
   output logic             fault,
   output logic             low_power,
   output logic             silent_bal
);
   localparam int N = `BCC_NCELL;
   // Address decode used by reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction
   // Bus phase registers
   logic        wr_r;       // Write data phase pending
   logic [7:0]  addr_r;     // Latched byte address
   logic [31:0] rdata_r;    // Read data, loaded at address phase
   // Software registers
   logic [5:0]  ctrl_r;     // Mode, resolution, sleep-continue
   logic [2*N-1:0] sel_r;   // Per-cell select fields
   logic [N-1:0] chen_r;    // Channel enables
   logic [`BCC_THR_W-1:0] thr_r [N];  // Per-cell thresholds
   // Balancing state
   bcc_state_t  st_r, st_nxt;
   bcc_pwr_t    pwr_r, pwr_nxt;
   logic [N-1:0] mask_r, mask_nxt;    // Cells still balancing
   logic [N-1:0] dis_r;               // Discharge drive
   logic [`BCC_CNT_W-1:0] gcnt_r, gcnt_nxt;  // Global counter
   logic [`BCC_CNT_W-1:0] wcnt_r, wcnt_nxt;  // Watchdog counter
   logic        wde_r;                // Watchdog expiry latch
   logic        wde_set;
   logic        wd_restart;
   // Per-cell decode
   logic [N-1:0] pick_vec;   // Enabled and selected at start
   logic [N-1:0] end_vec;    // Timed end reached
   logic [N-1:0] zero_vec;   // Threshold is zero
   logic [127:0] thr_flat;   // Thresholds one byte per cell

   // Address phase and command decode
   wire  addr_ph  = hsel && htrans[1] && hready;
   wire  wr_ctrl  = wr_r && hit(addr_r, `BCC_OFS_CTRL);
   wire  go_bit   = hwdata[`BCC_CTRL_GO];
   wire  halt_bit = hwdata[`BCC_CTRL_HALT];
   wire  cmd_start = wr_ctrl && go_bit && !halt_bit;
   wire  cmd_stop  = wr_ctrl && !go_bit && halt_bit;
   wire  wde_clr  = wr_r && hit(addr_r, `BCC_OFS_STAT) && hwdata[`BCC_STAT_WDE];
   wire  [1:0] mode = ctrl_r[`BCC_CTRL_MODE +: 2];
   wire  manual  = (mode == BCC_MODE_MANUAL);
   wire  timed   = (mode == BCC_MODE_TIMED);
   wire  coarse  = !ctrl_r[`BCC_CTRL_RES];
   wire  slp_cont = ctrl_r[`BCC_CTRL_SLPC];
   wire  sleep_evt = enter_sleep_command || comm_timeout;
   wire  ongoing = (st_r == BCC_ONGOING);
   wire  run_tick = ongoing && !conv_busy;
   wire  step_tick;
   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_r;
   // Shared step timebase for both counters
   bcc_step_tick #(
      .TICK_CYC (TICK_CYC),
      .RATIO    (`BCC_COARSE_RATIO)
   ) u_tick (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .clear      (!ongoing || wd_restart),
      .run        (run_tick),
      .coarse_sel (coarse),
      .step_tick  (step_tick)
   );

   // Per-cell logic, one copy for each cell
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_cell
         if (i < N) begin : g_real
            // Select pattern and channel enable both needed
            assign pick_vec[i] = chen_r[i] && (sel_r[2*i +: 2] == `BCC_SEL_PICK);
            assign zero_vec[i] = (thr_r[i] == '0);
            // Either counter at or past threshold ends cell; watchdog may lead after a mode switch
            assign end_vec[i] = zero_vec[i]
               || (gcnt_r >= {1'b0, thr_r[i]})
               || (wcnt_r >= {1'b0, thr_r[i]});
            assign thr_flat[8*i +: 8] = {1'b0, thr_r[i]};
            // Threshold byte write
            always_ff @(posedge clk_sys) begin
               if (rst) begin
                  thr_r[i] <= '0;
               end else if (wr_r && hit(addr_r,
                            8'(`BCC_OFS_THR0 + 4 * (i / 4)))) begin
                  thr_r[i] <= hwdata[8*(i%4) +: `BCC_THR_W];
               end
            end
         end else begin : g_pad
            assign thr_flat[8*i +: 8] = 8'h00;
         end
      end
   endgenerate
   // Balancing and power state next values
   always_comb begin
      st_nxt     = st_r;
      pwr_nxt    = pwr_r;
      mask_nxt   = mask_r;
      gcnt_nxt   = gcnt_r;
      wcnt_nxt   = wcnt_r;
      wde_set    = 1'b0;
      wd_restart = 1'b0;
      // Step counting, saturating
      if (ongoing && step_tick) begin
         if (timed && gcnt_r != '1) begin
            gcnt_nxt = gcnt_r + 1'b1;
         end
         if (wcnt_r != '1) begin
            wcnt_nxt = wcnt_r + 1'b1;
         end
      end
      // Timed mode: cells drop out on their own
      if (ongoing && timed) begin
         mask_nxt = mask_r & ~end_vec;
         if (mask_r == '0) begin
            st_nxt   = BCC_OVER;
            gcnt_nxt = '0;
         end
      end
      // Manual watchdog expiry
      if (ongoing && manual && wcnt_r >= WD_STEPS) begin
         st_nxt   = BCC_OVER;
         mask_nxt = '0;
         wde_set  = 1'b1;
      end
      // Start code; ignored once over until stopped
      if (cmd_start && (manual || timed)) begin
         if (st_r == BCC_IDLE) begin
            st_nxt     = BCC_ONGOING;
            mask_nxt   = pick_vec;
            gcnt_nxt   = '0;
            wcnt_nxt   = '0;
            wd_restart = 1'b1;
         end else if (ongoing && manual) begin
            wcnt_nxt   = '0;
            wd_restart = 1'b1;
         end
      end
      // Sleep entry or wake-up
      if (pwr_r == BCC_NORMAL && sleep_evt) begin
         if (ongoing && timed && slp_cont) begin
            pwr_nxt = BCC_SILENT;
         end else begin
            pwr_nxt  = BCC_SLEEP;
            st_nxt   = BCC_IDLE;
            mask_nxt = '0;
            gcnt_nxt = '0;
            wcnt_nxt = '0;
         end
      end else if (pwr_r != BCC_NORMAL && wake_request) begin
         pwr_nxt  = BCC_NORMAL;
         st_nxt   = BCC_IDLE;
         mask_nxt = '0;
         gcnt_nxt = '0;
         wcnt_nxt = '0;
      end
      // Stop code wins over state, mask and counters; power state and expiry latch still update
      if (cmd_stop) begin
         st_nxt   = BCC_IDLE;
         mask_nxt = '0;
         gcnt_nxt = '0;
         wcnt_nxt = '0;
      end
   end
   // State registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r   <= BCC_IDLE;
         pwr_r  <= BCC_NORMAL;
         mask_r <= '0;
         gcnt_r <= '0;
         wcnt_r <= '0;
      end else begin
         st_r   <= st_nxt;
         pwr_r  <= pwr_nxt;
         mask_r <= mask_nxt;
         gcnt_r <= gcnt_nxt;
         wcnt_r <= wcnt_nxt;
      end
   end
   // Drive held off during a conversion, mask kept for resume
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dis_r <= '0;
      end else begin
         dis_r <= (st_nxt == BCC_ONGOING && !conv_busy)
                  ? mask_nxt : '0;
      end
   end
   // Expiry latch; a new expiry beats a clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wde_r <= 1'b0;
      end else begin
         wde_r <= wde_set || (wde_r && !wde_clr);
      end
   end

   // Software register writes; mode applies at once
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_r <= `BCC_CTRL_RST;
         sel_r  <= `BCC_SEL_RST;
         chen_r <= `BCC_CHEN_RST;
      end else if (wr_r) begin
         if (hit(addr_r, `BCC_OFS_CTRL)) begin
            // Go and halt are strobes, not stored
            ctrl_r <= {hwdata[5:4], 2'h0, hwdata[1:0]};
         end
         if (hit(addr_r, `BCC_OFS_SEL)) begin
            sel_r <= hwdata[2*N-1:0];
         end
         if (hit(addr_r, `BCC_OFS_CHEN)) begin
            chen_r <= hwdata[N-1:0];
         end
      end
   end

   // Read mux, sampled at the address phase
   wire [31:0] stat_word = {27'h0, pwr_r == BCC_SLEEP,
      pwr_r == BCC_SILENT, wde_r, st_r == BCC_OVER, ongoing};
   wire [7:0]  ra = haddr[7:0];
   wire [31:0] rd_mux =
      hit(ra, `BCC_OFS_CTRL) ? {26'h0, ctrl_r} :
      hit(ra, `BCC_OFS_SEL)  ? {4'h0, sel_r} :
      hit(ra, `BCC_OFS_CHEN) ? {18'h0, chen_r} :
      hit(ra, `BCC_OFS_STAT) ? stat_word :
      hit(ra, `BCC_OFS_DIS)  ? {18'h0, dis_r} :
      hit(ra, `BCC_OFS_CNT)  ? {16'h0, wcnt_r, gcnt_r} :
      (ra[7:4] == 4'h2)      ? thr_flat[32*ra[3:2] +: 32] :
      32'h0;

   // Bus phase capture; unmapped reads return zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_r    <= 1'b0;
         addr_r  <= 8'h00;
         rdata_r <= 32'h0;
      end else begin
         wr_r   <= addr_ph && hwrite;
         addr_r <= haddr[7:0];
         if (addr_ph && !hwrite) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // Outputs
   assign discharge_en = dis_r;
   assign fault        = wde_r;
   assign low_power    = (pwr_r != BCC_NORMAL);
   assign silent_bal   = (pwr_r == BCC_SILENT);

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_stop_cmd;
      cmd_stop;
   endsequence
   sequence s_all_off;
      (st_r == BCC_IDLE) && (mask_r == '0);
   endsequence
   sequence s_start_idle;
      cmd_start && timed && st_r == BCC_IDLE && !sleep_evt && !wake_request && !conv_busy;
   endsequence
   AST_NEVER_BOTH: assert property (
      !(stat_word[`BCC_STAT_ACT] && stat_word[`BCC_STAT_DONE]) && st_r != 2'h2)
      else $error("illegal balancing state");
   AST_STOP: assert property (
      s_stop_cmd |=> s_all_off ##1 (dis_r == '0))
      else $error("stop code did not stop balancing");
   AST_START: assert property (
      s_start_idle |=> ongoing && mask_r == $past(pick_vec))
      else $error("start did not load enabled cells");
   AST_FROZEN: assert property (
      ongoing && !cmd_start && $stable(st_r)
      |-> (mask_nxt & ~mask_r) == '0)
      else $error("cell joined after start");
   AST_CONV_PAUSE: assert property (
      ongoing && conv_busy && !cmd_stop && pwr_r == BCC_NORMAL
      && !sleep_evt |=> dis_r == '0 && $stable(gcnt_r))
      else $error("balancing not paused by conversion");
   AST_ZERO_END: assert property (
      ongoing && timed && !cmd_start && (mask_r & zero_vec) != '0
      |=> (mask_r & $past(zero_vec)) == '0)
      else $error("zero threshold cell still balancing");
   AST_WD_FAULT: assert property (
      ongoing && manual && wcnt_r >= WD_STEPS && !cmd_stop
      |=> fault ##1 fault)
      else $error("watchdog expiry not latched");
   AST_ALL_DONE: assert property (
      ongoing && timed && mask_r == '0 && !cmd_stop && !cmd_start && !sleep_evt && !wake_request
      |=> st_r == BCC_OVER && gcnt_r == '0)
      else $error("timed end not reported");
   AST_MANUAL_SLEEP: assert property (
      ongoing && manual && sleep_evt && pwr_r == BCC_NORMAL
      |=> pwr_r == BCC_SLEEP && !ongoing ##1 dis_r == '0)
      else $error("manual balancing survived sleep");
   AST_SILENT: assert property (
      ongoing && timed && slp_cont && sleep_evt && !cmd_stop
      && pwr_r == BCC_NORMAL |=> silent_bal && ongoing)
      else $error("silent balancing not entered");
   AST_WAKE_STOP: assert property (
      low_power && wake_request |=> !low_power && !ongoing)
      else $error("balancing kept over wake-up");
endmodule

// ===== sim/bcc_host.sv
/*
 Host model: single-word AHB-Lite master that programs the balancer.
 Assumes one slave whose hreadyout comes back as hready.
*/
`timescale 1ns/1ns
`include "bcc_params.svh"
module bcc_host (
   // Clock
   input  wire logic        clk_sys,
   // Slave answer
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // Master request
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   // Bus idle at time zero, words only
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
   end
   // One transfer; no wait count assumed, hready decides both phases
   task automatic xfer(input logic [7:0] ofs, input logic is_wr, input logic [31:0] wd, output logic [31:0] rd_d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, ofs};
      htrans <= 2'h2;
      hwrite <= is_wr;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd_d = hrdata;
   endtask
   // Register write
   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(ofs, 1'b1, d, dummy);
   endtask
   // Register read, data taken at the data-phase edge
   task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
      xfer(ofs, 1'b0, 32'h00000000, d);
   endtask
   // Control word: sleep-continue, resolution, halt, go, mode
   function automatic logic [31:0] ctrl(input logic [1:0] mode, input logic go, input logic halt,
                                        input logic res, input logic slpc);
      ctrl = {26'h0000000, slpc, res, halt, go, mode};
   endfunction
   // Chosen cells get the pick code, the rest 00
   function automatic logic [31:0] sel(input logic [13:0] m);
      sel = 32'h00000000;
      for (int i = 0; i < `BCC_NCELL; i++) begin
         sel[2*i +: 2] = m[i] ? `BCC_SEL_PICK : 2'h0;
      end
   endfunction
   // New task: always back to idle before the start code
   task automatic run(input logic [1:0] mode, input logic res, input logic slpc);
      wr(`BCC_OFS_CTRL, ctrl(mode, 1'b0, 1'b1, res, slpc));
      wr(`BCC_OFS_CTRL, ctrl(mode, 1'b1, 1'b0, res, slpc));
   endtask
endmodule

// ===== sim/bcc_core_bench.sv
/*
 Self-checking bench of the cell balance controller against a step model.
 Assumes a step shortened to TICK cycles and a watchdog of WDS steps.
*/
`timescale 1ns/1ns
`include "bcc_params.svh"
module bcc_core_bench;
   localparam int TICK = 10; // Cycles per fine step, shortened
   localparam int WDS  = 5;  // Watchdog steps, shortened
   // Clock, reset, events {wake, comm timeout, sleep}, conversion
   logic        clk_sys;
   logic        rst;
   logic [2:0]  ev;
   logic        conv;
   // Bus
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic        hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   // Outputs
   logic [13:0] discharge_en;
   logic        fault;
   logic        low_power;
   logic        silent_bal;
   // Model state and scoring
   int          fails;
   int          tests_run;
   int          n;
   int          thr_m[16];
   logic [13:0] mask_m;
   logic [13:0] chen_m;
   logic [31:0] v;

   // Design; one slave, so hready is its own hreadyout
   bcc_core #(.TICK_CYC(TICK), .WD_STEPS(8'(WDS))) bcc_core_i (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .enter_sleep_command(ev[0]), .comm_timeout(ev[1]), .wake_request(ev[2]),
      .conv_busy(conv), .discharge_en(discharge_en), .fault(fault), .low_power(low_power),
      .silent_bal(silent_bal));
   // Host on the register bus
   bcc_host bcc_host_i (
      .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   // 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Verdict and end of run
   task automatic finish_test();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Compare any result
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Compare a register read
   task automatic chk_reg(input string what, input logic [7:0] ofs, input logic [31:0] exp);
      logic [31:0] d;
      bcc_host_i.rd(ofs, d);
      cmp(what, exp, d);
   endtask
   // Wait n edges, then let updates settle
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // One-cycle power event
   task automatic pulse(input int i);
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev[i] <= 1'b0;
      cyc(2);
   endtask
   // Model thresholds into the four threshold words
   task automatic load_thr();
      logic [31:0] w;
      for (int a = 0; a < `BCC_THR_WORDS; a++) begin
         for (int b = 0; b < 4; b++) begin
            w[8*b +: 8] = 8'(thr_m[4*a+b]);
         end
         bcc_host_i.wr(8'(`BCC_OFS_THR0 + 4*a), w);
      end
   endtask
   // Model: a selected cell drives while fewer than thr steps passed
   function automatic logic [13:0] exp_dis(input int k);
      for (int i = 0; i < `BCC_NCELL; i++) begin
         exp_dis[i] = mask_m[i] && thr_m[i] > k;
      end
   endfunction
   // Hang guard, well beyond the planned run
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      finish_test();
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      ev = 3'h0;
      conv = 1'b0;
      fails = 0;
      tests_run = 0;
      thr_m = '{default: 0};
      v = $urandom(32'h797C);
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      cyc(2);
      // Reset state and an unmapped word
      cmp("pins", 32'h0, {hresp, silent_bal, low_power, fault, discharge_en});
      chk_reg("stat", `BCC_OFS_STAT, 32'h0);
      chk_reg("unmapped", 8'h40, 32'h0);
      // Manual on random cells; coarse steps keep the watchdog away
      mask_m = 14'($urandom) | 14'h0001;
      chen_m = 14'($urandom) | 14'h0001;
      bcc_host_i.wr(`BCC_OFS_CHEN, {18'h0, chen_m});
      bcc_host_i.wr(`BCC_OFS_SEL, bcc_host_i.sel(mask_m));
      bcc_host_i.run(2'h0, 1'b0, 1'b0);
      chk_reg("stat_m00", `BCC_OFS_STAT, 32'h0);
      bcc_host_i.run(2'h3, 1'b0, 1'b0);
      chk_reg("stat_m11", `BCC_OFS_STAT, 32'h0);
      bcc_host_i.run(2'h1, 1'b0, 1'b0);
      cyc(1);
      cmp("dis_manual", mask_m & chen_m, discharge_en);
      chk_reg("stat_on", `BCC_OFS_STAT, 32'h1);
      bcc_host_i.wr(`BCC_OFS_CHEN, 32'h0);
      bcc_host_i.wr(`BCC_OFS_SEL, 32'h0);
      bcc_host_i.wr(`BCC_OFS_CTRL, bcc_host_i.ctrl(2'h1, 1'b1, 1'b1, 1'b0, 1'b0));
      bcc_host_i.wr(`BCC_OFS_CTRL, bcc_host_i.ctrl(2'h1, 1'b0, 1'b0, 1'b0, 1'b0));
      cyc(1);
      cmp("dis_frozen", mask_m & chen_m, discharge_en);
      bcc_host_i.wr(`BCC_OFS_CTRL, bcc_host_i.ctrl(2'h1, 1'b0, 1'b1, 1'b0, 1'b0));
      cyc(1);
      cmp("dis_stop", 32'h0, discharge_en);
      // Manual watchdog on fine steps
      mask_m = 14'h3FFF;
      bcc_host_i.wr(`BCC_OFS_CHEN, 32'h3FFF);
      bcc_host_i.wr(`BCC_OFS_SEL, bcc_host_i.sel(mask_m));
      bcc_host_i.run(2'h1, 1'b1, 1'b0);
      cyc(3 * TICK);
      // A second start part way through must restart the watchdog count
      bcc_host_i.wr(`BCC_OFS_CTRL, bcc_host_i.ctrl(2'h1, 1'b1, 1'b0, 1'b1, 1'b0));
      n = 0;
      while (fault !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      cmp("wd_time", 32'h1, 32'(n >= (WDS-1)*TICK && n <= (WDS+1)*TICK));
      cmp("dis_wd", 32'h0, discharge_en);
      chk_reg("stat_wd", `BCC_OFS_STAT, 32'h6);
      bcc_host_i.wr(`BCC_OFS_STAT, 32'h4);
      cyc(1);
      cmp("fault_clr", 32'h0, fault);
      bcc_host_i.wr(`BCC_OFS_CTRL, bcc_host_i.ctrl(2'h1, 1'b0, 1'b1, 1'b1, 1'b0));
      chk_reg("stat_idle", `BCC_OFS_STAT, 32'h0);
      // Timed, fourteen cells, a conversion pause of 19 edges midway
      for (int i = 0; i < `BCC_NCELL; i++) begin
         thr_m[i] = $urandom_range(7);
      end
      thr_m[0] = 0;
      thr_m[13] = 7;
      load_thr();
      bcc_host_i.run(2'h2, 1'b1, 1'b0);
      cyc(5);
      for (int k = 0; k < 9; k++) begin
         cmp("dis_timed", exp_dis(k), discharge_en);
         if (k == 1) begin
            @(posedge clk_sys);
            conv <= 1'b1;
            cyc(10);
            cmp("dis_conv", 32'h0, discharge_en);
            repeat (9) @(posedge clk_sys);
            conv <= 1'b0;
         end
         cyc(TICK);
      end
      chk_reg("stat_done", `BCC_OFS_STAT, 32'h2);
      bcc_host_i.rd(`BCC_OFS_CNT, v);
      cmp("cnt_clr", 32'h0, {24'h0, v[7:0]});
      // Manual to timed switch: zero thresholds end at once
      for (int i = 0; i < `BCC_NCELL; i++) begin
         thr_m[i] = (i % 2) * 6;
      end
      load_thr();
      bcc_host_i.run(2'h1, 1'b1, 1'b0);
      cyc(1);
      cmp("dis_pre", 32'h3FFF, discharge_en);
      bcc_host_i.wr(`BCC_OFS_CTRL, bcc_host_i.ctrl(2'h2, 1'b0, 1'b0, 1'b1, 1'b0));
      cyc(1);
      cmp("dis_switch", exp_dis(0), discharge_en);
      // Sleep cases: manual/timed by sleep-continue, then wake
      thr_m = '{default: 7};
      load_thr();
      for (int c = 0; c < 4; c++) begin
         bcc_host_i.run(c < 2 ? 2'h1 : 2'h2, 1'b0, c[0]);
         pulse(c[0] ^ c[1]);
         cmp("low_power", 32'h1, low_power);
         cmp("silent", 32'(c == 3), silent_bal);
         cmp("dis_lp", c == 3 ? 32'h3FFF : 32'h0, discharge_en);
         pulse(2);
         cmp("dis_wake", 32'h0, {low_power, discharge_en});
         chk_reg("stat_wake", `BCC_OFS_STAT, 32'h0);
      end
      // Coarse step of 128 fine steps, one cell with threshold 1
      thr_m[0] = 1;
      mask_m = 14'h0001;
      load_thr();
      bcc_host_i.wr(`BCC_OFS_SEL, bcc_host_i.sel(mask_m));
      bcc_host_i.run(2'h2, 1'b0, 1'b0);
      cyc(`BCC_COARSE_RATIO * TICK - 20);
      cmp("dis_coarse_on", 32'h1, discharge_en);
      cyc(40);
      cmp("dis_coarse_off", 32'h0, discharge_en);
      chk_reg("stat_coarse", `BCC_OFS_STAT, 32'h2);
      finish_test();
   end
endmodule
